// *** rtl/tpf_core.sv ***
/*
  Two-word instruction prefetch queue with bus-cycle and clock accounting.
  A one-cycle start pulse presents an instruction (kind, modes, size); the block
  then runs its bus cycles in prefetch order and counts clock periods.
  Assumes memory pulses i_mem_rdy one clock into each cycle, later by its waits,
  and that i_mem_rdy comes from a pin (so it is synchronised here).
*/
// Functional notes
// - Keep a two word prefetch queue
// - Opword decoded, next word fetched at start
// - Refill one slot per consumed extension word
// - Last fetch when opword dropped
// - Branching single word wastes second prefetch
// - Interrupt or trace discards both prefetched words
// - PC holds last fetched stream address
// - Bus cycle is four clocks nominal
// - Wait states add clocks to total
// - Count includes fetches, operand reads, stores
// - EA never writes; register and abs long costs
// - Indirect, postinc, immediate cost four/eight
// - Predecrement adds two clocks
// - Displacement, abs short, pc_displacement_mode eight/twelve
// - Indexed modes ten/fourteen, any index_reg size
// - Register moves four, to indirect eight
// - Abs long to abs long byte move 28
// - Long moves twelve and thirty six
`timescale 1ns/100ps
`default_nettype none
module tpf_core (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic i_is_move,
  input wire logic i_is_long,
  input wire logic [3:0] i_src_mode,
  input wire logic [3:0] i_dst_mode,
  input wire logic i_branch,
  input wire logic i_exception,
  input wire logic [23:0] i_target,
  input wire logic i_mem_rdy,
  output logic o_busy,
  output logic o_rd_strobe,
  output logic o_wr_strobe,
  output logic o_istream,
  output logic [23:0] o_pc,
  output logic [1:0] o_queue_valid,
  output logic [15:0] o_clk_count,
  output logic [3:0] o_rd_count,
  output logic [3:0] o_wr_count,
  output logic o_done
);
  // Sequencer states
  typedef enum logic [2:0] {TPF_IDLE, TPF_INT, TPF_BUS, TPF_DONE} tpf_st_t;

  // Synchroniser on the memory ready pin
  logic rdy_meta_r, rdy_sync_r;
  // Sequencer state and its next value
  tpf_st_t st_r, st_nxt;
  // Pending istream fetches, operand reads, writes and internal clocks
  logic [3:0] ifetch_r, ifetch_nxt;
  logic [3:0] oread_r, oread_nxt;
  logic [3:0] owrite_r, owrite_nxt;
  logic [7:0] intc_r, intc_nxt;
  // Program counter: address of last fetched stream word
  logic [23:0] pc_r, pc_nxt;
  // Queue occupancy bits
  logic [1:0] qv_r, qv_nxt;
  // Accumulated totals
  logic [15:0] clk_r, clk_nxt;
  logic [3:0] rd_r, rd_nxt;
  logic [3:0] wr_r, wr_nxt;
  // Current bus cycle kind: 1 = stream fetch
  logic cyc_if_r, cyc_if_nxt;
  logic cyc_wr_r, cyc_wr_nxt;
  logic done_r, done_nxt;
  // Decoded request fields
  tpf_pkg::tpf_ea_t src_m, dst_m;
  logic [3:0] ext_tot, src_rd, dst_wr;
  logic [7:0] int_tot;

  assign src_m = tpf_pkg::tpf_ea_t'(i_src_mode);
  assign dst_m = tpf_pkg::tpf_ea_t'(i_dst_mode);

  // Request decode: moves have two modes, others only a source
  always_comb
  begin
    // Extension words cost one stream fetch each
    ext_tot = {1'b0, tpf_pkg::tpf_ext_words(src_m, i_is_long)};
    src_rd = {1'b0, tpf_pkg::tpf_opnd_words(src_m, i_is_long)};
    int_tot = tpf_pkg::tpf_int_clks(src_m);
    dst_wr = 4'h0;
    if (i_is_move)
    begin
      // Destination cost is extension words, index clocks and stores, no predec penalty
      ext_tot = ext_tot + {1'b0, tpf_pkg::tpf_ext_words(dst_m, 1'b0)};
      if (dst_m == tpf_pkg::TPF_EA_INDEX)
        int_tot = int_tot + tpf_pkg::TPF_INDEX_CLKS;
      if (dst_m != tpf_pkg::TPF_EA_DREG && dst_m != tpf_pkg::TPF_EA_AREG)
        dst_wr = i_is_long ? 4'h2 : 4'h1;
      int_tot = int_tot + tpf_pkg::TPF_MOVE_INT_CLKS;
    end
  end

  // Two-flop synchroniser; only the second flop is read
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdy_meta_r <= 1'b0;
      rdy_sync_r <= 1'b0;
    end
    else
    begin
      rdy_meta_r <= i_mem_rdy;
      rdy_sync_r <= rdy_meta_r;
    end
  end

  // Sequencer next state; stream fetches run before operand cycles
  always_comb
  begin
    st_nxt = st_r;
    ifetch_nxt = ifetch_r;
    oread_nxt = oread_r;
    owrite_nxt = owrite_r;
    intc_nxt = intc_r;
    pc_nxt = pc_r;
    qv_nxt = qv_r;
    clk_nxt = clk_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    cyc_if_nxt = cyc_if_r;
    cyc_wr_nxt = cyc_wr_r;
    done_nxt = 1'b0;
    case (st_r)
      TPF_IDLE:
      begin
        if (i_start)
        begin
          // Opword decoded and next word already held at entry
          qv_nxt = 2'b11;
          clk_nxt = 16'h0000;
          rd_nxt = 4'h0;
          wr_nxt = 4'h0;
          // Own refetches plus the final one when opword is dropped
          ifetch_nxt = ext_tot + 4'h1;
          oread_nxt = src_rd;
          owrite_nxt = dst_wr;
          intc_nxt = int_tot;
          if (i_branch || i_exception)
          begin
            // Queued words are dropped unused; refill both from target
            qv_nxt = 2'b00;
            ifetch_nxt = i_exception ? 4'h2 : ext_tot + 4'h2;
            pc_nxt = i_target - tpf_pkg::TPF_PC_STEP;
          end
          st_nxt = TPF_INT;
        end
      end
      TPF_INT:
      begin
        // Internal clocks first, then bus cycles
        if (intc_r != 8'h00)
        begin
          intc_nxt = intc_r - 8'h01;
          clk_nxt = clk_r + 16'h0001;
        end
        else if (ifetch_r != 4'h0 || oread_r != 4'h0 || owrite_r != 4'h0)
        begin
          cyc_if_nxt = (ifetch_r != 4'h0);
          cyc_wr_nxt = (ifetch_r == 4'h0) && (oread_r == 4'h0);
          st_nxt = TPF_BUS;
        end
        else
          st_nxt = TPF_DONE;
      end
      TPF_BUS:
      begin
        // Every bus clock counts, so wait states add themselves
        clk_nxt = clk_r + 16'h0001;
        if (rdy_sync_r)
        begin
          if (cyc_if_r)
          begin
            ifetch_nxt = ifetch_r - 4'h1;
            pc_nxt = pc_r + tpf_pkg::TPF_PC_STEP;
            qv_nxt = {qv_r[0], 1'b1};
            rd_nxt = rd_r + 4'h1;
          end
          else if (cyc_wr_r)
          begin
            owrite_nxt = owrite_r - 4'h1;
            wr_nxt = wr_r + 4'h1;
          end
          else
          begin
            oread_nxt = oread_r - 4'h1;
            rd_nxt = rd_r + 4'h1;
          end
          st_nxt = TPF_INT;
        end
      end
      TPF_DONE:
      begin
        done_nxt = 1'b1;
        st_nxt = TPF_IDLE;
      end
      default: st_nxt = TPF_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_r <= TPF_IDLE;
      ifetch_r <= 4'h0;
      oread_r <= 4'h0;
      owrite_r <= 4'h0;
      intc_r <= 8'h00;
      pc_r <= tpf_pkg::TPF_PC_RST;
      qv_r <= 2'b00;
      clk_r <= 16'h0000;
      rd_r <= 4'h0;
      wr_r <= 4'h0;
      cyc_if_r <= 1'b0;
      cyc_wr_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      ifetch_r <= ifetch_nxt;
      oread_r <= oread_nxt;
      owrite_r <= owrite_nxt;
      intc_r <= intc_nxt;
      pc_r <= pc_nxt;
      qv_r <= qv_nxt;
      clk_r <= clk_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      cyc_if_r <= cyc_if_nxt;
      cyc_wr_r <= cyc_wr_nxt;
      done_r <= done_nxt;
    end
  end

  // Outputs; strobes are combinational handshake signals
  assign o_busy = (st_r != TPF_IDLE);
  assign o_rd_strobe = (st_r == TPF_BUS) && !cyc_wr_r;
  assign o_wr_strobe = (st_r == TPF_BUS) && cyc_wr_r;
  assign o_istream = (st_r == TPF_BUS) && cyc_if_r;
  assign o_pc = pc_r;
  assign o_queue_valid = qv_r;
  assign o_clk_count = clk_r;
  assign o_rd_count = rd_r;
  assign o_wr_count = wr_r;
  assign o_done = done_r;

  // Effective address processing never writes while fetching
  chk_no_fetch_write: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_istream |-> !o_wr_strobe) else $error("write during stream fetch");
  // Entry fills both queue slots for a plain start
  chk_queue_full_entry: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (st_r == TPF_IDLE && i_start && !i_branch && !i_exception) |=> qv_r == 2'b11)
    else $error("queue not full at entry");
  // Exceptions discard both words
  chk_exc_discard: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (st_r == TPF_IDLE && i_start && i_exception) |=> qv_r == 2'b00)
    else $error("queue kept on exception");
  // Stream fetch advances the program counter by one word
  chk_pc_step: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (o_istream && rdy_sync_r) |=> pc_r == $past(pc_r) + tpf_pkg::TPF_PC_STEP)
    else $error("pc did not advance");
  // Every clock of a bus cycle is counted
  chk_bus_clk_count: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (st_r == TPF_BUS) |=> clk_r == $past(clk_r) + 16'h0001)
    else $error("bus clock not counted");
  // A stream fetch ends with the read count up by one
  chk_fetch_counted: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (o_istream && rdy_sync_r) |=> rd_r == $past(rd_r) + 4'h1)
    else $error("fetch not counted");
  // Done follows idle-bound completion for one cycle
  chk_done_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_done |=> !o_done) else $error("done longer than a cycle");
  // Branch leaves queue empty until refetch
  chk_branch_refill: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (st_r == TPF_IDLE && i_start && i_branch) |=> (qv_r == 2'b00 && ifetch_r >= 4'h2))
    else $error("branch refill wrong");
  // Both slots are refilled by the time an instruction reports done
  chk_done_queue_full: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_done |-> qv_r == 2'h3)
    else $error("queue not refilled at done");
  // An exception fetches exactly the two target words and nothing of its own
  chk_exc_two_fetch: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (st_r == TPF_IDLE && i_start && i_exception) |=> ifetch_r == 4'h2)
    else $error("exception fetch count wrong");
  // No strobe may stand while the sequencer is idle
  chk_idle_no_strobe: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !o_busy |-> (!o_rd_strobe && !o_wr_strobe))
    else $error("strobe while idle");
endmodule // tpf_core
`default_nettype wire

// *** rtl/tpf_pkg.sv ***
/*
  Package for the two-word prefetch and cycle accounting block.
  Holds bus timing, queue depth, addressing-mode codes and cost tables.
  Assumes a single 100 MHz clock domain and no software-visible registers.
*/
`default_nettype none
package tpf_pkg;
  // Queue depth in words
  localparam int unsigned TPF_QDEPTH = 2;
  // Clock periods per zero-wait bus cycle
  localparam logic [7:0] TPF_BUS_CLKS = 8'h04;
  // Extra clocks of the predecrement modes
  localparam logic [7:0] TPF_PREDEC_CLKS = 8'h02;
  // Extra clocks of the indexed modes over displacement modes
  localparam logic [7:0] TPF_INDEX_CLKS = 8'h02;
  // Internal move clocks that are not bus cycles (zero for moves)
  localparam logic [7:0] TPF_MOVE_INT_CLKS = 8'h00;
  // Reset value of the program counter
  localparam logic [23:0] TPF_PC_RST = 24'h00_0000;
  // Step between instruction-stream words in bytes
  localparam logic [23:0] TPF_PC_STEP = 24'h00_0002;

  // Effective address mode codes
  typedef enum logic [3:0] {
    TPF_EA_DREG, TPF_EA_AREG, TPF_EA_IND, TPF_EA_POSTINC, TPF_EA_PREDEC,
    TPF_EA_DISP, TPF_EA_INDEX, TPF_EA_ABSW, TPF_EA_ABSL, TPF_EA_PCDISP,
    TPF_EA_PCINDEX, TPF_EA_IMM
  } tpf_ea_t;

  // Extension words of each mode for byte/word and long operands
  function automatic logic [2:0] tpf_ext_words(input tpf_ea_t m, input logic is_long);
    case (m)
      TPF_EA_DISP, TPF_EA_INDEX, TPF_EA_ABSW, TPF_EA_PCDISP, TPF_EA_PCINDEX:
        tpf_ext_words = 3'h1;
      TPF_EA_ABSL: tpf_ext_words = 3'h2;
      TPF_EA_IMM: tpf_ext_words = is_long ? 3'h2 : 3'h1;
      default: tpf_ext_words = 3'h0;
    endcase
  endfunction

  // Memory operand words read by a source mode
  function automatic logic [2:0] tpf_opnd_words(input tpf_ea_t m, input logic is_long);
    case (m)
      TPF_EA_DREG, TPF_EA_AREG, TPF_EA_IMM: tpf_opnd_words = 3'h0;
      default: tpf_opnd_words = is_long ? 3'h2 : 3'h1;
    endcase
  endfunction

  // Internal clocks of a mode beyond its bus cycles
  function automatic logic [7:0] tpf_int_clks(input tpf_ea_t m);
    case (m)
      TPF_EA_PREDEC: tpf_int_clks = TPF_PREDEC_CLKS;
      TPF_EA_INDEX, TPF_EA_PCINDEX: tpf_int_clks = TPF_INDEX_CLKS;
      default: tpf_int_clks = 8'h00;
    endcase
  endfunction
endpackage
`default_nettype wire

// *** testbench/tpf_mem_model.sv ***
/*
  Memory partner for the prefetch block: answers every bus cycle.
  Assumes strobes stand until the block has seen the ready pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module tpf_mem_model (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_rd_strobe,
  input wire logic i_wr_strobe,
  input wire logic [3:0] i_waits,
  output logic o_mem_rdy
);
  // Clocks seen in the current bus cycle
  logic [4:0] age_r;
  // One-cycle ready pulse one clock after the first strobe clock, later by the wait count;
  // the block's two-flop synchroniser stretches that to four clocks nominal.
  // A pulse, not a level, so a sloppy strobe release is not forgiven
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      age_r <= 5'h00;
      o_mem_rdy <= 1'b0;
    end
    else if (i_rd_strobe | i_wr_strobe)
    begin
      age_r <= age_r + 5'h01;
      o_mem_rdy <= (age_r == {1'b0, i_waits});
    end
    else
    begin
      // Idle bus: no answer stands
      age_r <= 5'h00;
      o_mem_rdy <= 1'b0;
    end
  end
endmodule // tpf_mem_model
`default_nettype wire

// *** testbench/two_word_prefetch_timing_tb.sv ***
/*
  Self-checking bench for the prefetch and cycle accounting block.
  Assumes the memory partner model and the core of rtl/.
*/
`timescale 1ns/100ps
`default_nettype none
module two_word_prefetch_timing_tb;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic st = 1'b0, mv = 1'b0, lg = 1'b0, br = 1'b0, ex = 1'b0;
  logic [3:0] sm = 4'h0, dm = 4'h0, waits = 4'h0;
  logic [23:0] tgt = 24'h00_0000;
  logic rdy, busy, rd, wr, istr, done;
  logic [23:0] pc;
  logic [1:0] qv;
  logic [15:0] clks;
  logic [3:0] rds, wrs;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Clocks with a stream fetch on the bus, sampled where settled
  int istr_clks = 0;
  // Byte/word effective address clocks by mode code
  logic [7:0] ea_bw [12] = '{0, 0, 4, 4, 6, 8, 10, 8, 12, 8, 10, 4};

  always #5 i_sys_clk = ~i_sys_clk;

  // Falling edge keeps clear of the strobe's launch edge
  always @(negedge i_sys_clk)
  begin
    if (istr === 1'b1)
      istr_clks++;
  end

  tpf_core uut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_start(st), .i_is_move(mv),
    .i_is_long(lg), .i_src_mode(sm), .i_dst_mode(dm), .i_branch(br), .i_exception(ex),
    .i_target(tgt), .i_mem_rdy(rdy), .o_busy(busy), .o_rd_strobe(rd), .o_wr_strobe(wr),
    .o_istream(istr), .o_pc(pc), .o_queue_valid(qv), .o_clk_count(clks),
    .o_rd_count(rds), .o_wr_count(wrs), .o_done(done));
  tpf_mem_model mem (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_rd_strobe(rd),
    .i_wr_strobe(wr), .i_waits(waits), .o_mem_rdy(rdy));

  task automatic complete_run();
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic chk_addr(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %0t address %h expected %h", $time, got, exp);
    end
  endtask

  // Pulse start with one instruction, then wait for its done under a bound
  task automatic issue(input logic m, l, b, e, input logic [3:0] s, d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    {st, mv, lg, br, ex, sm, dm} <= {1'b1, m, l, b, e, s, d};
    @(posedge i_sys_clk);
    st <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 900)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (n == 900)
      chk_cnt(16'h0000, 16'h0001);
  endtask

  task automatic cost(input logic [15:0] c, r, w);
    chk_cnt(clks, c);
    chk_cnt({12'h000, rds}, r);
    chk_cnt({12'h000, wrs}, w);
  endtask

  // Every source mode, both sizes, into a data register
  task automatic t_ea_modes();
    logic [7:0] c;
    for (int m = 0; m < 12; m++)
      for (int l = 0; l < 2; l++)
      begin
        c = ea_bw[m] + ((l == 1 && ea_bw[m] != 0) ? 8'h04 : 8'h00);
        issue(1'b1, l[0], 1'b0, 1'b0, m[3:0], 4'h0);
        cost(16'h0004 + c, 16'h0001 + c[7:2], 16'h0000);
      end
  endtask

  // Register and absolute long moves into memory
  task automatic t_moves();
    issue(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h2);
    cost(16'h0008, 16'h0001, 16'h0001);
    issue(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 4'h2);
    cost(16'h000C, 16'h0001, 16'h0002);
    issue(1'b1, 1'b0, 1'b0, 1'b0, 4'h8, 4'h8);
    cost(16'h001C, 16'h0006, 16'h0001);
    issue(1'b1, 1'b1, 1'b0, 1'b0, 4'h8, 4'h8);
    cost(16'h0024, 16'h0007, 16'h0002);
  endtask

  // Two waits on each of the two bus cycles of a store
  task automatic t_waits();
    waits <= 4'h2;
    issue(1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 4'h2);
    cost(16'h000C, 16'h0001, 16'h0001);
    waits <= 4'h0;
  endtask

  // Program counter steps once per stream word, extensions included
  task automatic t_pc_walk();
    logic [23:0] p;
    int f;
    p = pc;
    f = istr_clks;
    issue(1'b1, 1'b0, 1'b0, 1'b0, 4'h8, 4'h0);
    chk_addr(pc, p + 24'h00_0006);
    chk_cnt(16'(istr_clks - f), 16'h000C);
    chk_addr({22'h00_0000, qv}, 24'h00_0003);
  endtask

  // Branch refills from the target; exception discards and refills
  task automatic t_flow();
    @(posedge i_sys_clk) tgt <= 24'h00_4A10;
    issue(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 4'h0);
    cost(16'h0008, 16'h0002, 16'h0000);
    chk_addr(pc, 24'h00_4A12);
    @(posedge i_sys_clk) tgt <= 24'h00_0C00;
    issue(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4'h0);
    cost(16'h0008, 16'h0002, 16'h0000);
    chk_addr(pc, 24'h00_0C02);
    chk_addr({22'h00_0000, qv}, 24'h00_0003);
  endtask

  // A start while busy is ignored: first request's counts, one done only
  task automatic t_refused();
    fork
      issue(1'b1, 1'b0, 1'b0, 1'b0, 4'h2, 4'h0);
      begin
        repeat (3) @(posedge i_sys_clk);
        {st, br} <= 2'b11;
        @(posedge i_sys_clk);
        {st, br} <= 2'b00;
      end
    join
    cost(16'h0008, 16'h0002, 16'h0000);
    repeat (30)
    begin
      @(posedge i_sys_clk);
      #1;
      chk_cnt({15'h0000, done | busy}, 16'h0000);
    end
  endtask

  // Mid-run reset clears counts, queue and program counter; work resumes
  task automatic t_reset();
    @(posedge i_sys_clk) i_nrst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk_addr(pc, 24'h00_0000);
    chk_addr({22'h00_0000, qv}, 24'h00_0000);
    cost(16'h0000, 16'h0000, 16'h0000);
    @(posedge i_sys_clk) i_nrst <= 1'b1;
    issue(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
    cost(16'h0004, 16'h0001, 16'h0000);
  endtask

  // Cycle ceiling well above the whole sequence
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      $display("mismatch %0t run did not finish", $time);
      complete_run();
    end
  end

  initial
  begin
    repeat (3) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    #1;
    chk_addr(pc, 24'h00_0000);
    t_ea_modes();
    t_moves();
    t_waits();
    t_pc_walk();
    t_flow();
    t_refused();
    t_reset();
    complete_run();
  end
endmodule // two_word_prefetch_timing_tb
`default_nettype wire
